// file: core/iox_defs.vh
// register map, reset values and bus constants of the i2c io expander
`ifndef IOX_DEFS_VH
`define IOX_DEFS_VH

`define IOX_REG_IN_LOW    3'h0
`define IOX_REG_IN_HIGH   3'h1
`define IOX_REG_OUT_LOW   3'h2
`define IOX_REG_OUT_HIGH  3'h3
`define IOX_REG_INV_LOW   3'h4
`define IOX_REG_INV_HIGH  3'h5
`define IOX_REG_DIR_LOW   3'h6
`define IOX_REG_DIR_HIGH  3'h7

`define IOX_OUT_RESET     8'hff
`define IOX_INV_RESET     8'h00
`define IOX_DIR_RESET     8'hff
`define IOX_CMD_RESET     3'h0
`define IOX_INIT_CYCLES   2'h3

`define IOX_ADDR_FIXED    4'h4
`define IOX_ADDR_FIXED_W  4
`define IOX_BITS_PER_BYTE 4'h8

`endif

// file: core/iox_expander.v
// i2c slave sixteen bit io expander with per port change interrupt
//
// Overview of operation
// - answer slave address 0100 plus three select pins, 32 to 39.
// - address lsb one means read, zero means write.
// - first written byte after address is command; low three bits pick register.
// - command only taken in writes; reads keep using the selected register.
// - input registers return live pin levels; writes to them ignored.
// - output latches reset to ones; reads return latch, not pin.
// - output latch drives pin only when pin is an output.
// - inversion bit one inverts reported input; inversion registers reset zero.
// - direction one is input, zero drives; direction resets to all ones.
// - reset loads all defaults and idles the bus state machine.
// - edge on input pin raises active low interrupt; outputs never do.
// - interrupt clears on pin return, read of its port, or stop.
// - read clear takes effect at the acknowledge bit after scl falls.
// - interrupt sources tracked per port; reads clear only own port.
// - other slaves' traffic leaves interrupt alone; each new change re-raises.
// - switching output to input may raise a spurious interrupt.
// - write data alternates between the two registers of the pair.
// - repeated start stores the register being accessed as command.
// - read bytes alternate between the pair for as long as acknowledged.
// - pin levels captured for readout at rising edge of acknowledge clock.
// - general call address is never acknowledged.
// - acknowledge matching address and every received byte by pulling sda low.
`timescale 1ns/10ps
`include "iox_defs.vh"

module iox_expander #(
    parameter PORT_W = 8
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    input wire addr_sel_bit_zero_i,
    input wire addr_sel_bit_one_i,
    input wire addr_sel_bit_two_i,
    input wire [PORT_W-1:0] low_port_pins_i,
    output wire [PORT_W-1:0] low_port_pins_o,
    output wire [PORT_W-1:0] low_port_pins_oe_o,
    input wire [PORT_W-1:0] high_port_pins_i,
    output wire [PORT_W-1:0] high_port_pins_o,
    output wire [PORT_W-1:0] high_port_pins_oe_o,
    output wire int_n_o,
    output wire int_n_oe_o
);

    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_AACK = 3'd2;
    localparam ST_CMD = 3'd3;
    localparam ST_WACK = 3'd4;
    localparam ST_WDATA = 3'd5;
    localparam ST_RDATA = 3'd6;
    localparam ST_RACK = 3'd7;
    localparam SYNC_W = 2 + 3 + 2 * PORT_W;

    // two flip-flop synchroniser for every pin input
    reg [SYNC_W-1:0] sync1_q;
    reg [SYNC_W-1:0] sync2_q;
    wire [SYNC_W-1:0] raw_in;
    assign raw_in = {scl_i, sda_i, addr_sel_bit_two_i, addr_sel_bit_one_i,
                     addr_sel_bit_zero_i, high_port_pins_i, low_port_pins_i};

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_q <= {SYNC_W{1'b1}};
            sync2_q <= {SYNC_W{1'b1}};
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    wire scl_s;
    wire sda_s;
    wire [2:0] asel_s;
    wire [PORT_W-1:0] pin_lo_s;
    wire [PORT_W-1:0] pin_hi_s;
    assign scl_s = sync2_q[SYNC_W-1];
    assign sda_s = sync2_q[SYNC_W-2];
    assign asel_s = sync2_q[2*PORT_W+2:2*PORT_W];
    assign pin_hi_s = sync2_q[2*PORT_W-1:PORT_W];
    assign pin_lo_s = sync2_q[PORT_W-1:0];

    reg scl_d_q;
    reg sda_d_q;
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
        end
    end

    wire scl_rise;
    wire scl_fall;
    wire start_ev;
    wire stop_ev;
    assign scl_rise = scl_s & ~scl_d_q;
    assign scl_fall = ~scl_s & scl_d_q;
    assign start_ev = scl_s & scl_d_q & sda_d_q & ~sda_s;
    assign stop_ev = scl_s & scl_d_q & ~sda_d_q & sda_s;

    // register file
    reg [PORT_W-1:0] out_lo_q;
    reg [PORT_W-1:0] out_hi_q;
    reg [PORT_W-1:0] inv_lo_q;
    reg [PORT_W-1:0] inv_hi_q;
    reg [PORT_W-1:0] dir_lo_q;
    reg [PORT_W-1:0] dir_hi_q;
    reg [2:0] cmd_q;
    reg [2:0] ptr_q;

    // bus engine state
    reg [2:0] state_q;
    reg [3:0] cnt_q;
    reg [7:0] sh_q;
    reg [7:0] tx_q;
    reg rw_q;
    reg sel_q;
    reg mack_q;
    reg sda_oe_q;

    // interrupt reference levels per port
    reg [PORT_W-1:0] ref_lo_q;
    reg [PORT_W-1:0] ref_hi_q;
    reg [1:0] init_cnt_q;
    reg irq_q;
    wire init_done;
    assign init_done = (init_cnt_q == `IOX_INIT_CYCLES);

    // input registers read live pins through inversion
    function [7:0] rd_reg;
        input [2:0] idx;
        begin
            rd_reg = 8'h00;
            if (idx == `IOX_REG_IN_LOW) begin
                rd_reg = pin_lo_s ^ inv_lo_q;
            end else if (idx == `IOX_REG_IN_HIGH) begin
                rd_reg = pin_hi_s ^ inv_hi_q;
            end else if (idx == `IOX_REG_OUT_LOW) begin
                rd_reg = out_lo_q;
            end else if (idx == `IOX_REG_OUT_HIGH) begin
                rd_reg = out_hi_q;
            end else if (idx == `IOX_REG_INV_LOW) begin
                rd_reg = inv_lo_q;
            end else if (idx == `IOX_REG_INV_HIGH) begin
                rd_reg = inv_hi_q;
            end else if (idx == `IOX_REG_DIR_LOW) begin
                rd_reg = dir_lo_q;
            end else begin
                rd_reg = dir_hi_q;
            end
        end
    endfunction

    wire [6:0] own_addr;
    assign own_addr = {`IOX_ADDR_FIXED, asel_s};
    wire byte_full;
    assign byte_full = (cnt_q == `IOX_BITS_PER_BYTE);
    wire [2:0] ptr_alt;
    assign ptr_alt = {ptr_q[2:1], ~ptr_q[0]};

    // bus state machine and register writes
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'hff;
            rw_q <= 1'b0;
            sel_q <= 1'b0;
            mack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            cmd_q <= `IOX_CMD_RESET;
            ptr_q <= `IOX_CMD_RESET;
            out_lo_q <= `IOX_OUT_RESET;
            out_hi_q <= `IOX_OUT_RESET;
            inv_lo_q <= `IOX_INV_RESET;
            inv_hi_q <= `IOX_INV_RESET;
            dir_lo_q <= `IOX_DIR_RESET;
            dir_hi_q <= `IOX_DIR_RESET;
        end else if (stop_ev) begin
            state_q <= ST_IDLE;
            sel_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (start_ev) begin
            // repeated start remembers the register in use
            if (sel_q) begin
                cmd_q <= ptr_q;
            end
            state_q <= ST_ADDR;
            cnt_q <= 4'h0;
            sel_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (scl_rise) begin
            case (state_q)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    sh_q <= {sh_q[6:0], sda_s};
                    cnt_q <= cnt_q + 4'h1;
                end
                ST_RDATA: begin
                    cnt_q <= cnt_q + 4'h1;
                end
                ST_AACK: begin
                    // capture pins for first read byte
                    if (rw_q) begin
                        tx_q <= rd_reg(ptr_q);
                    end
                end
                ST_RACK: begin
                    // acknowledged read moves to the pair partner
                    mack_q <= ~sda_s;
                    if (!sda_s) begin
                        ptr_q <= ptr_alt;
                        tx_q <= rd_reg(ptr_alt);
                    end
                end
                default: begin
                    cnt_q <= 4'h0;
                end
            endcase
        end else if (scl_fall) begin
            case (state_q)
                ST_ADDR: begin
                    if (byte_full) begin
                        cnt_q <= 4'h0;
                        if (sh_q[7:1] == own_addr) begin
                            sda_oe_q <= 1'b1;
                            sel_q <= 1'b1;
                            rw_q <= sh_q[0];
                            state_q <= ST_AACK;
                            ptr_q <= cmd_q;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (rw_q) begin
                        sda_oe_q <= ~tx_q[7];
                        state_q <= ST_RDATA;
                    end else begin
                        sda_oe_q <= 1'b0;
                        state_q <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (byte_full) begin
                        cmd_q <= sh_q[2:0];
                        ptr_q <= sh_q[2:0];
                        cnt_q <= 4'h0;
                        sda_oe_q <= 1'b1;
                        state_q <= ST_WACK;
                    end
                end
                ST_WACK: begin
                    sda_oe_q <= 1'b0;
                    state_q <= ST_WDATA;
                end
                ST_WDATA: begin
                    if (byte_full) begin
                        cnt_q <= 4'h0;
                        sda_oe_q <= 1'b1;
                        state_q <= ST_WACK;
                        // next byte goes to the pair partner
                        ptr_q <= ptr_alt;
                        if (ptr_q == `IOX_REG_OUT_LOW) begin
                            out_lo_q <= sh_q;
                        end else if (ptr_q == `IOX_REG_OUT_HIGH) begin
                            out_hi_q <= sh_q;
                        end else if (ptr_q == `IOX_REG_INV_LOW) begin
                            inv_lo_q <= sh_q;
                        end else if (ptr_q == `IOX_REG_INV_HIGH) begin
                            inv_hi_q <= sh_q;
                        end else if (ptr_q == `IOX_REG_DIR_LOW) begin
                            dir_lo_q <= sh_q;
                        end else if (ptr_q == `IOX_REG_DIR_HIGH) begin
                            dir_hi_q <= sh_q;
                        end
                    end
                end
                ST_RDATA: begin
                    if (byte_full) begin
                        cnt_q <= 4'h0;
                        sda_oe_q <= 1'b0;
                        state_q <= ST_RACK;
                    end else begin
                        tx_q <= {tx_q[6:0], 1'b1};
                        sda_oe_q <= ~tx_q[6];
                    end
                end
                ST_RACK: begin
                    if (mack_q) begin
                        sda_oe_q <= ~tx_q[7];
                        state_q <= ST_RDATA;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // read of an input port at its acknowledge bit
    wire rd_clear;
    assign rd_clear = scl_fall & ~stop_ev & ~start_ev & (state_q == ST_RDATA) & byte_full;
    wire stop_clear;
    assign stop_clear = stop_ev & sel_q;

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_lo_q <= {PORT_W{1'b0}};
            ref_hi_q <= {PORT_W{1'b0}};
            init_cnt_q <= 2'h0;
        end else begin
            // references follow the pins until the synchroniser holds real levels
            if (!init_done) begin
                init_cnt_q <= init_cnt_q + 2'h1;
            end
            // clear on stop or read at the acknowledge bit
            if (!init_done || stop_clear || (rd_clear && ptr_q == `IOX_REG_IN_LOW)) begin
                ref_lo_q <= pin_lo_s;
            end
            // only traffic to this device touches the references
            if (!init_done || stop_clear || (rd_clear && ptr_q == `IOX_REG_IN_HIGH)) begin
                ref_hi_q <= pin_hi_s;
            end
        end
    end

    // any input pin differing from its reference raises the line
    wire irq_d;
    assign irq_d = init_done & (|((pin_lo_s ^ ref_lo_q) & dir_lo_q) |
                             |((pin_hi_s ^ ref_hi_q) & dir_hi_q));

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign int_n_o = 1'b0;
    assign int_n_oe_o = irq_q;
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe_q;

    // latch drives pin only where direction is output
    assign low_port_pins_o = out_lo_q;
    assign high_port_pins_o = out_hi_q;
    assign low_port_pins_oe_o = ~dir_lo_q;
    assign high_port_pins_oe_o = ~dir_hi_q;

endmodule // iox_expander

// file: verif/iox_chk_top_chk.sv
// port assertions for the i2c io expander
`timescale 1ns/10ps
module iox_chk #(
    parameter PORT_W = 8
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire scl_i,
    input wire sda_o,
    input wire sda_oe_o,
    input wire [PORT_W-1:0] low_port_pins_i,
    input wire [PORT_W-1:0] low_port_pins_o,
    input wire [PORT_W-1:0] low_port_pins_oe_o,
    input wire [PORT_W-1:0] high_port_pins_oe_o,
    input wire int_n_o,
    input wire int_n_oe_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    AST_SDA_OD: assert property (sda_o == 1'b0)
        else $error("sda data value not low");
    AST_INT_OD: assert property (int_n_o == 1'b0)
        else $error("interrupt data value not low");
    AST_RST_VAL: assert property ($rose(reset_n_i) |-> !sda_oe_o && !int_n_oe_o
        && low_port_pins_o == '1 && low_port_pins_oe_o == '0 && high_port_pins_oe_o == '0)
        else $error("outputs not at defaults after reset");
    AST_SDA_LAT: assert property ($changed(sda_oe_o) |->
        !scl_i && !$past(scl_i, 2) && $past(scl_i, 6))
        else $error("sda drive moved outside the scl low phase");
    AST_SDA_HOLD: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
        else $error("sda drive changed while scl high");
    AST_PIN_UPD: assert property ($changed({low_port_pins_o, low_port_pins_oe_o}) |->
        !scl_i && $past(scl_i, 6))
        else $error("port update away from an acknowledge");
    AST_OUT_QUIET: assert property ((&low_port_pins_oe_o && &high_port_pins_oe_o)[*8] |->
        !int_n_oe_o)
        else $error("interrupt with every pin an output");
    AST_INT_UP: assert property (!int_n_oe_o && scl_i &&
        |((low_port_pins_i ^ $past(low_port_pins_i)) & ~low_port_pins_oe_o)
        ##1 $stable(low_port_pins_i)[*6] |-> ##[0:4] int_n_oe_o)
        else $error("input pin change raised no interrupt");
endmodule // iox_chk

bind iox_expander iox_chk #(.PORT_W(PORT_W)) u_chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .low_port_pins_i(low_port_pins_i), .low_port_pins_o(low_port_pins_o),
    .low_port_pins_oe_o(low_port_pins_oe_o), .high_port_pins_oe_o(high_port_pins_oe_o),
    .int_n_o(int_n_o), .int_n_oe_o(int_n_oe_o)
);

// file: verif/iox_mst.sv
// i2c bus master model driving the expander link
`timescale 1ns/10ps
module iox_mst (
    input wire clk_i,
    input wire sda_i,
    output logic scl_o,
    output logic sda_o
);
    // quarter of the 125 ns link period
    localparam real Q = 31.25;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // data set while scl low, line sampled in the high phase
    task automatic bit_x(input logic b, output logic r);
        sda_o = b;
        #Q scl_o = 1'b1;
        #Q r = sda_i;
        #Q scl_o = 1'b0;
        #Q;
    endtask
    task automatic start;
        @(posedge clk_i);
        // offset keeps every later link edge clear of a clock edge
        #1.1;
        sda_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_o = 1'b0;
        #Q scl_o = 1'b0;
        #Q;
    endtask
    task automatic stop;
        sda_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_o = 1'b1;
        #Q;
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    task automatic rd(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(~ack, r);
    endtask
endmodule // iox_mst

// file: verif/testbench.sv
// self-checking bench for the i2c io expander
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] sel = 3'h5;
    logic [7:0] ext_lo = 8'h5a;
    logic [7:0] ext_hi = 8'hc3;
    logic ack;
    logic [7:0] b0, b1;
    integer error_cnt = 0;
    integer n_checks = 0;
    wire scl, m_sda, sda_oe, int_oe;
    wire [7:0] lo_o, lo_oe, hi_o, hi_oe, lo_in, hi_in;
    // open-drain data line with pull-up
    wire sda = m_sda & ~sda_oe;
    assign lo_in = (lo_o & lo_oe) | (ext_lo & ~lo_oe);
    assign hi_in = (hi_o & hi_oe) | (ext_hi & ~hi_oe);
    always #2 clk = ~clk;
    iox_mst u_mst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
    iox_expander u_dut (
        .clk_i(clk), .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(sda_oe), .addr_sel_bit_zero_i(sel[0]), .addr_sel_bit_one_i(sel[1]),
        .addr_sel_bit_two_i(sel[2]), .low_port_pins_i(lo_in), .low_port_pins_o(lo_o),
        .low_port_pins_oe_o(lo_oe), .high_port_pins_i(hi_in), .high_port_pins_o(hi_o),
        .high_port_pins_oe_o(hi_oe), .int_n_o(), .int_n_oe_o(int_oe)
    );
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic addr(input logic rd);
        u_mst.start();
        u_mst.wr({4'h4, sel, rd}, ack);
        chk(ack, 1'b1);
    endtask
    task automatic wreg(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
        addr(1'b0);
        u_mst.wr(cmd, ack);
        u_mst.wr(d0, ack);
        u_mst.wr(d1, ack);
        chk(ack, 1'b1);
        u_mst.stop();
    endtask
    // command, restart, one or two bytes; caller sends the stop
    task automatic rreg(input logic [7:0] cmd, input logic two);
        addr(1'b0);
        u_mst.wr(cmd, ack);
        addr(1'b1);
        u_mst.rd(two, b0);
        if (two)
            u_mst.rd(1'b0, b1);
    endtask
    task automatic pin(input logic [7:0] lo, input logic [7:0] hi);
        @(posedge clk);
        ext_lo <= lo;
        ext_hi <= hi;
        repeat (12) @(posedge clk);
        #1;
    endtask
    task automatic t_reset;
        chk({lo_oe, hi_oe, lo_o}, 24'h0000ff);
        chk(int_oe, 1'b0);
        for (int i = 3; i < 8; i += 2) begin
            rreg(i[7:0], 1'b1);
            u_mst.stop();
            chk({b0, b1}, (i == 5) ? 16'h0000 : 16'hffff);
        end
    endtask
    task automatic t_addr;
        logic [7:0] bad [3] = '{8'h00, 8'h48, 8'h5a};
        for (int i = 0; i < 3; i++) begin
            u_mst.start();
            u_mst.wr(bad[i], ack);
            chk(ack, 1'b0);
            u_mst.wr(8'h02, ack);
            u_mst.wr(8'h00, ack);
            u_mst.stop();
        end
        rreg(8'h02, 1'b0);
        u_mst.stop();
        chk(b0, 8'hff);
        for (int i = 0; i < 8; i += 7) begin
            @(posedge clk);
            sel <= i[2:0];
            repeat (4) @(posedge clk);
            addr(1'b0);
            chk(ack, 1'b1);
            u_mst.stop();
        end
        @(posedge clk);
        sel <= 3'h5;
    endtask
    task automatic t_pairs;
        wreg(8'h03, 8'ha5, 8'h3c);
        rreg(8'h02, 1'b1);
        u_mst.stop();
        chk({b0, b1}, 16'h3ca5);
        addr(1'b0);
        u_mst.wr(8'h03, ack);
        u_mst.wr(8'h77, ack);
        addr(1'b1);
        u_mst.rd(1'b1, b0);
        u_mst.rd(1'b0, b1);
        u_mst.stop();
        chk({b0, b1}, 16'h3c77);
        addr(1'b1);
        u_mst.rd(1'b0, b0);
        u_mst.stop();
        chk(b0, 8'h3c);
        wreg(8'h00, 8'h12, 8'h34);
        rreg(8'h00, 1'b1);
        u_mst.stop();
        chk({b0, b1}, {ext_lo, ext_hi});
    endtask
    task automatic t_dir;
        wreg(8'h02, 8'h96, 8'h69);
        wreg(8'h04, 8'h00, 8'hf0);
        wreg(8'h06, 8'h00, 8'hff);
        chk({lo_oe, hi_oe, lo_in}, {16'hff00, 8'h96});
        rreg(8'h00, 1'b1);
        u_mst.stop();
        chk({b0, b1}, {8'h96, ext_hi ^ 8'hf0});
        rreg(8'h03, 1'b1);
        u_mst.stop();
        chk({b0, b1, hi_in}, {16'h6996, ext_hi});
        wreg(8'h06, 8'h00, 8'h00);
        chk({lo_in, hi_in}, 16'h9669);
        pin(8'ha5, 8'h3c);
        chk(int_oe, 1'b0);
        pin(8'h5a, 8'hc3);
        wreg(8'h04, 8'h00, 8'h00);
        wreg(8'h06, 8'hff, 8'hff);
    endtask
    task automatic t_irq;
        pin(8'h5b, 8'hc3);
        chk(int_oe, 1'b1);
        pin(8'h5a, 8'hc3);
        chk(int_oe, 1'b0);
        pin(8'h5a, 8'h43);
        rreg(8'h00, 1'b0);
        chk({b0, int_oe}, 9'h0b5);
        u_mst.stop();
        chk(int_oe, 1'b0);
        pin(8'h5a, 8'h42);
        chk(int_oe, 1'b1);
        rreg(8'h01, 1'b0);
        chk(int_oe, 1'b0);
        u_mst.stop();
        pin(8'h5a, 8'h43);
        u_mst.start();
        u_mst.wr(8'h48, ack);
        u_mst.stop();
        chk(int_oe, 1'b1);
        pin(8'h5a, 8'h42);
        chk(int_oe, 1'b0);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        t_reset();
        t_addr();
        t_pairs();
        t_dir();
        t_irq();
        test_done();
    end
    initial begin
        #300000;
        error_cnt++;
        test_done();
    end
endmodule // testbench
